/* design/frt_pkg.sv */
// Shared constants and types of the free-running timer with output compare
package frt_pkg;

  // ----------------------------------------------------------------
  // Widths and prescaler
  // ----------------------------------------------------------------
  localparam int          COUNT_W     = 16;    // Counter and compare width
  localparam int          IDX_W       = 6;     // Register index width
  localparam int          PHASE_W     = 2;     // Divide-by-four prescaler
  localparam logic [1:0]  STEP_PHASE  = 2'h3;  // Phase that advances count
  localparam logic [1:0]  MATCH_PHASE = 2'h0;  // Phase that compares
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX   = 16'hffff;

  // ----------------------------------------------------------------
  // Register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_CAP1_HI = 6'h20;
  localparam logic [5:0] IDX_CAP1_LO = 6'h21;
  localparam logic [5:0] IDX_CMP1_HI = 6'h22;
  localparam logic [5:0] IDX_CMP1_LO = 6'h23;
  localparam logic [5:0] IDX_CAP2_HI = 6'h24;
  localparam logic [5:0] IDX_CAP2_LO = 6'h25;
  localparam logic [5:0] IDX_CMP2_HI = 6'h26;
  localparam logic [5:0] IDX_CMP2_LO = 6'h27;
  localparam logic [5:0] IDX_CNT_HI  = 6'h28;
  localparam logic [5:0] IDX_CNT_LO  = 6'h29;
  localparam logic [5:0] IDX_ALT_HI  = 6'h2a;
  localparam logic [5:0] IDX_ALT_LO  = 6'h2b;
  localparam logic [5:0] IDX_CTL1    = 6'h2c;
  localparam logic [5:0] IDX_CTL2    = 6'h2d;
  localparam logic [5:0] IDX_STATUS  = 6'h2e;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL1_IRQ_CAP1   = 7;
  localparam int CTL1_IRQ_CAP2   = 6;
  localparam int CTL1_IRQ_MATCH1 = 5;
  localparam int CTL1_IRQ_OVF    = 4;
  localparam int CTL1_OUT_EN1    = 3;
  localparam int CTL1_LEVEL1     = 0;
  localparam int CTL2_IRQ_MATCH2 = 5;
  localparam int CTL2_OUT_EN2    = 3;
  localparam int CTL2_LEVEL2     = 0;
  localparam int STAT_MATCH1     = 5;
  localparam int STAT_OVF        = 4;
  localparam int STAT_CAP_PIN1   = 3;
  localparam int STAT_CAP_PIN2   = 2;
  localparam int STAT_MATCH2     = 1;

  // ----------------------------------------------------------------
  // Per-channel control carried into a compare channel
  // ----------------------------------------------------------------
  typedef struct packed {
    logic level;         // Level loaded into the pin latch on a match
    logic out_en;        // Drive the latched level, else hold low
    logic pin_is_input;  // Shared pin is an input: no drive, no match
  } chan_ctrl_s;

endpackage

/* design/compare_channel.sv */
// One 16-bit output compare channel: value, inhibit, flag and pin latch
`timescale 1ns/100ps
`default_nettype none

module compare_channel
  import frt_pkg::*;
(
  // Clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_rst_b,
  // Timer side
  input  wire logic               i_match_phase,
  input  wire logic [COUNT_W-1:0] i_count,
  input  wire chan_ctrl_s         i_ctrl,
  // Register access
  input  wire logic               i_wr_hi,
  input  wire logic               i_wr_lo,
  input  wire logic               i_lo_acc,
  input  wire logic               i_stat_rd,
  input  wire logic [7:0]         i_wdata,
  // Results
  output logic [COUNT_W-1:0]      o_value,
  output logic                    o_flag,
  output logic                    o_pin,
  output logic                    o_pin_oe
);

  logic inhibit;   // Compares held off after a high-byte write
  logic armed;     // Status was read with the flag set
  logic level_q;   // Output level latch
  logic hit;       // Match in this counter state
  logic clr;       // Flag clear on armed low-byte access

  // ----------------------------------------------------------------
  // Match detection
  // ----------------------------------------------------------------
  // One phase per counter value, never while inhibited or pin is input
  assign hit = i_match_phase & ~inhibit & ~i_ctrl.pin_is_input &
               (i_count == o_value); // R7 R18 R21
  assign clr = i_lo_acc & armed;

  // Compare value: bytes written alone, no reset, no hardware update
  always_ff @(posedge i_clk) begin
    if (i_wr_hi) begin
      o_value[15:8] <= i_wdata; // R6 R13 R15
    end
    if (i_wr_lo) begin
      o_value[7:0] <= i_wdata; // R13
    end
  end

  // Inhibit from high-byte write until the low byte is written
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      inhibit <= 1'b0;
    end else if (i_wr_hi) begin
      inhibit <= 1'b1; // R11
    end else if (i_wr_lo) begin
      inhibit <= 1'b0; // R11
    end
  end

  // Match flag: set wins over clear, untouched by reset
  always_ff @(posedge i_clk) begin
    if (hit) begin
      o_flag <= 1'b1; // R7 R15
    end else if (clr) begin
      o_flag <= 1'b0;
    end
  end

  // Arm for clearing on a status read that sees the flag
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      armed <= 1'b0;
    end else if (i_stat_rd && o_flag) begin
      armed <= 1'b1;
    end else if (clr) begin
      armed <= 1'b0;
    end
  end

  // Level latch loads on every match, flag state regardless
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      level_q <= 1'b0;
    end else if (hit) begin
      level_q <= i_ctrl.level; // R14
    end
  end

  // Pin drive: low while disabled, released while the pin is input
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pin    <= 1'b0;
      o_pin_oe <= 1'b0;
    end else begin
      o_pin    <= i_ctrl.out_en & (hit ? i_ctrl.level : level_q); // R20
      o_pin_oe <= ~i_ctrl.pin_is_input; // R18
    end
  end

endmodule

`default_nettype wire

/* design/frt_timer.sv */
// Free-running 16-bit timer with two output compare channels, Wishbone
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none

// Function
// R1: 16-bit counter steps every four clocks
// R2: counter steps on its phase; reads harmless
// R3: lone low-byte read returns live count
// R4: high read latches low byte until low read
// R5: alternate pair never touches overflow flag
// R6: compare values software-only, kept through reset
// R7: compare per step; match sets flag, pin
// R8: match flags at status bits 5 and 1
// R9: channel two level at control two bit 0
// R10: match interrupt only when enable set
// R11: high-byte write suspends compares until low
// R12: software must follow high write with low
// R13: byte writes leave other byte intact
// R14: level latch loads on every match
// R15: flags and compare values not reset; the overflow flag is cleared by reset
// R16: software init: high, status read, low
// R17: software masks interrupts around two-byte access
// R18: input-configured pin undriven, register still storage
// R19: overflow set on wrap, cleared by sequence
// R20: output enable reset clear, output held low
// R21: one match event per counter value
module frt_timer
  import frt_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // Wishbone classic slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  // Port pins
  input  wire logic [1:0]  i_capture_pin,
  input  wire logic [1:0]  i_pin_is_input,
  output logic      [1:0]  o_compare_pin,
  output logic      [1:0]  o_compare_pin_oe,
  // Interrupt request
  output logic             o_timer_irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [PHASE_W-1:0] prescale;     // Divide-by-four phase
  logic               step;         // Counter advance enable
  logic               match_phase;  // Compare enable
  logic [COUNT_W-1:0] count;        // Free-running counter
  logic [7:0]         lo_buf;       // Latched low byte
  logic               lo_held;      // Two-byte read in progress
  logic               ovf_flag;     // Overflow flag
  logic               ovf_arm;      // Status read saw overflow
  logic [7:3]         ctl1_hi;      // Enables in control one
  logic [2:0]         ctl1_lo;      // Edge and level bits, no reset
  logic               match_ie2;    // Channel two interrupt enable
  logic               out_en2;      // Channel two output enable
  logic               level2;       // Channel two output level
  logic               take;         // Request accepted this cycle
  logic               rd;           // Accepted read
  logic               wr;           // Accepted write on lane 0
  logic [IDX_W-1:0]   idx;          // Register index
  logic [7:0]         wdata;        // Write byte
  logic               rd_cnt_hi;    // Read of either counter high byte
  logic               rd_cnt_lo;    // Read of either counter low byte
  logic               rd_stat;      // Read of status
  logic [7:0]         next_rdata;   // Read data mux
  logic [COUNT_W-1:0] cmp_val [2];  // Compare values
  logic [1:0]         match_flag;   // Match flags per channel
  chan_ctrl_s         chan_ctrl [2]; // Per-channel control

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // One request per cycle; ack gap blocks a repeat take
  assign take      = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign rd        = take & ~i_wb_we;
  assign wr        = take & i_wb_we & i_wb_sel[0];
  assign idx       = i_wb_adr[7:2];
  assign wdata     = i_wb_dat[7:0];
  assign rd_cnt_hi = rd & ((idx == IDX_CNT_HI) | (idx == IDX_ALT_HI));
  assign rd_cnt_lo = rd & ((idx == IDX_CNT_LO) | (idx == IDX_ALT_LO));
  assign rd_stat   = rd & (idx == IDX_STATUS);

  // ----------------------------------------------------------------
  // Prescaler and counter
  // ----------------------------------------------------------------
  assign step        = (prescale == STEP_PHASE);
  assign match_phase = (prescale == MATCH_PHASE);

  // Fixed divide by four, no programmable ratio
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + 2'h1; // R1
    end
  end

  // Counter advances only on its step, bus reads never touch it
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count <= COUNT_RESET;
    end else if (step) begin
      count <= count + 16'h0001; // R1 R2
    end
  end

  // ----------------------------------------------------------------
  // Coherent two-byte counter read
  // ----------------------------------------------------------------
  // First high read latches the low byte; low read ends the sequence
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lo_held <= 1'b0;
      lo_buf  <= 8'h00;
    end else if (rd_cnt_hi && !lo_held) begin
      lo_held <= 1'b1; // R4
      lo_buf  <= count[7:0]; // R4
    end else if (rd_cnt_lo) begin
      lo_held <= 1'b0; // R4
    end
  end

  // ----------------------------------------------------------------
  // Overflow flag
  // ----------------------------------------------------------------
  // Arm on status read that sees the flag
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ovf_arm <= 1'b0;
    end else if (rd_stat && ovf_flag) begin
      ovf_arm <= 1'b1; // R19
    end else if (rd && (idx == IDX_CNT_HI || idx == IDX_CNT_LO)) begin
      ovf_arm <= 1'b0;
    end
  end

  // Set on wrap wins over clear; alternate pair never clears
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ovf_flag <= 1'b0;
    end else if (step && count == COUNT_MAX) begin
      ovf_flag <= 1'b1; // R19
    end else if (ovf_arm && rd &&
                 (idx == IDX_CNT_HI || idx == IDX_CNT_LO)) begin
      ovf_flag <= 1'b0; // R5 R19
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Enable bits cleared by reset
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctl1_hi   <= 5'h00; // R20
      match_ie2 <= 1'b0;
      out_en2   <= 1'b0; // R20
    end else if (wr && idx == IDX_CTL1) begin
      ctl1_hi <= wdata[7:3];
    end else if (wr && idx == IDX_CTL2) begin
      match_ie2 <= wdata[CTL2_IRQ_MATCH2]; // R10
      out_en2   <= wdata[CTL2_OUT_EN2];
    end
  end

  // Edge and level bits keep their value through reset
  always_ff @(posedge i_clk) begin
    if (wr && idx == IDX_CTL1) begin
      ctl1_lo <= wdata[2:0];
    end
    if (wr && idx == IDX_CTL2) begin
      level2 <= wdata[CTL2_LEVEL2]; // R9
    end
  end

  // ----------------------------------------------------------------
  // Compare channels
  // ----------------------------------------------------------------
  assign chan_ctrl[0] = '{level:        ctl1_lo[CTL1_LEVEL1],
                          out_en:       ctl1_hi[CTL1_OUT_EN1],
                          pin_is_input: i_pin_is_input[0]};
  assign chan_ctrl[1] = '{level:        level2, // R9
                          out_en:       out_en2,
                          pin_is_input: i_pin_is_input[1]};

  // One channel per compare register pair
  for (genvar g = 0; g < 2; g++) begin : g_chan
    localparam logic [5:0] HI = (g == 0) ? IDX_CMP1_HI : IDX_CMP2_HI;
    localparam logic [5:0] LO = (g == 0) ? IDX_CMP1_LO : IDX_CMP2_LO;

    compare_channel u_chan (
      .i_clk         (i_clk),
      .i_rst_b       (i_rst_b),
      .i_match_phase (match_phase),
      .i_count       (count),
      .i_ctrl        (chan_ctrl[g]),
      .i_wr_hi       (wr && idx == HI),
      .i_wr_lo       (wr && idx == LO),
      .i_lo_acc      (take && idx == LO),
      .i_stat_rd     (rd_stat),
      .i_wdata       (wdata),
      .o_value       (cmp_val[g]),
      .o_flag        (match_flag[g]),
      .o_pin         (o_compare_pin[g]),
      .o_pin_oe      (o_compare_pin_oe[g])
    );
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Capture registers and reserved bits read as zero
  always_comb begin
    next_rdata = 8'h00;
    case (idx)
      IDX_CMP1_HI: next_rdata = cmp_val[0][15:8];
      IDX_CMP1_LO: next_rdata = cmp_val[0][7:0];
      IDX_CMP2_HI: next_rdata = cmp_val[1][15:8];
      IDX_CMP2_LO: next_rdata = cmp_val[1][7:0];
      IDX_CNT_HI,
      IDX_ALT_HI:  next_rdata = count[15:8];
      IDX_CNT_LO,
      IDX_ALT_LO:  next_rdata = lo_held ? lo_buf : count[7:0]; // R3 R4
      IDX_CTL1:    next_rdata = {ctl1_hi, ctl1_lo};
      IDX_CTL2: begin
        next_rdata[CTL2_IRQ_MATCH2] = match_ie2;
        next_rdata[CTL2_OUT_EN2]    = out_en2;
        next_rdata[CTL2_LEVEL2]     = level2;
      end
      IDX_STATUS: begin
        next_rdata[STAT_MATCH1]   = match_flag[0]; // R8
        next_rdata[STAT_OVF]      = ovf_flag;
        next_rdata[STAT_CAP_PIN1] = i_capture_pin[0];
        next_rdata[STAT_CAP_PIN2] = i_capture_pin[1];
        next_rdata[STAT_MATCH2]   = match_flag[1]; // R8
      end
      default:     next_rdata = 8'h00;
    endcase
  end

  // Registered answer one cycle after the request is taken
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= take;
      if (rd) begin
        o_wb_dat <= {24'h00_0000, next_rdata};
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request
  // ----------------------------------------------------------------
  // Each source gated by its own enable
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_timer_irq <= 1'b0;
    end else begin
      o_timer_irq <= (match_flag[0] & ctl1_hi[CTL1_IRQ_MATCH1]) |
                     (match_flag[1] & match_ie2) | // R10
                     (ovf_flag & ctl1_hi[CTL1_IRQ_OVF]);
    end
  end

endmodule

`default_nettype wire

/* bench/frt_timer_chk.sv */
// Port checker for the free-running timer, bound to its top module
`timescale 1ns/100ps
`default_nettype none
module frt_timer_chk
  import frt_pkg::*;
(
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  // Wishbone
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        i_wb_we,
  input wire logic [7:0]  i_wb_adr,
  input wire logic [3:0]  i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  // Pins
  input wire logic [1:0]  i_capture_pin,
  input wire logic [1:0]  i_pin_is_input,
  input wire logic [1:0]  o_compare_pin,
  input wire logic [1:0]  o_compare_pin_oe,
  input wire logic        o_timer_irq
);
  // ----------------------------------------------------------------
  // Mirrors
  // ----------------------------------------------------------------
  logic [1:0]  ph;       // Prescaler phase
  logic [15:0] cnt;      // Counter
  logic [7:0]  lat;      // Latched low byte
  logic        pend;     // High read seen
  logic [7:0]  cmp [4];  // Compare bytes
  logic [3:0]  known = 4'h0; // Bytes written, kept through reset
  logic [7:0]  exp_d;    // Expected read byte
  logic [1:0]  exp_v;    // Counter, compare expectation
  logic        unm;      // Unmapped read taken
  logic [1:0]  en;       // Output enables
  logic [2:0]  ien;      // Interrupt enables
  wire [5:0] idx = i_wb_adr[7:2];
  wire take = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire rd = take & ~i_wb_we;
  wire wr = take & i_wb_we & i_wb_sel[0];
  wire is_cmp = (idx[5:3] == 3'h4) & idx[1];
  wire [1:0] k = {idx[2], idx[0]};
  wire is_hi = (idx == IDX_CNT_HI) | (idx == IDX_ALT_HI);
  wire is_lo = (idx == IDX_CNT_LO) | (idx == IDX_ALT_LO);

  // Counter steps on the last prescaler phase
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ph <= 2'h0;
      cnt <= COUNT_RESET;
    end else begin
      ph <= ph + 2'h1;
      if (ph == STEP_PHASE) cnt <= cnt + 16'h0001;
    end
  end

  // Low byte latch and expected read data
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pend <= 1'b0;
      lat <= 8'h00;
      exp_v <= 2'h0;
      exp_d <= 8'h00;
      unm <= 1'b0;
    end else begin
      exp_v <= 2'h0;
      unm <= rd & ((idx < 6'h20) | (idx > 6'h2e));
      if (rd & is_hi) begin
        exp_v <= 2'h1;
        exp_d <= cnt[15:8];
        if (!pend) lat <= cnt[7:0];
        pend <= 1'b1;
      end
      if (rd & is_lo) begin
        exp_v <= 2'h1;
        exp_d <= pend ? lat : cnt[7:0];
        pend <= 1'b0;
      end
      if (rd & is_cmp) begin
        exp_v <= {known[k], 1'b0};
        exp_d <= cmp[k];
      end
    end
  end

  // Compare bytes and their marks are never reset
  always_ff @(posedge i_clk) begin
    if (wr & is_cmp) cmp[k] <= i_wb_dat[7:0];
    if (wr & is_cmp) known[k] <= 1'b1;
  end

  // Output and interrupt enables, cleared by reset
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      en <= 2'h0;
      ien <= 3'h0;
    end else begin
      if (wr & (idx == IDX_CTL1)) begin
        en[0] <= i_wb_dat[CTL1_OUT_EN1];
        ien[1:0] <= {i_wb_dat[CTL1_IRQ_OVF], i_wb_dat[CTL1_IRQ_MATCH1]};
      end
      if (wr & (idx == IDX_CTL2)) begin
        en[1] <= i_wb_dat[CTL2_OUT_EN2];
        ien[2] <= i_wb_dat[CTL2_IRQ_MATCH2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  AST_ACK_PULSE:
    assert property (take |=> o_wb_ack ##1 !o_wb_ack)
    else $error("ack not a single pulse");
  AST_ACK_CAUSE:
    assert property ($rose(o_wb_ack) |-> $past(i_wb_cyc & i_wb_stb))
    else $error("ack without request");
  AST_DAT_UPPER:
    assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h000000)
    else $error("upper read data not zero");
  AST_UNMAPPED:
    assert property (unm |-> o_wb_ack && o_wb_dat == 32'h00000000)
    else $error("unmapped read not zero");
  AST_CNT_READ:
    assert property (exp_v[0] |-> o_wb_ack && o_wb_dat[7:0] == exp_d)
    else $error("counter read mismatch");
  AST_CMP_READ:
    assert property (exp_v[1] |-> o_wb_ack && o_wb_dat[7:0] == exp_d)
    else $error("compare read mismatch");
  AST_OE_INPUT:
    assert property ($past(i_rst_b) |->
                     o_compare_pin_oe == ~$past(i_pin_is_input))
    else $error("pin drive enable wrong");
  AST_PIN_LOW:
    assert property ((o_compare_pin & ~$past(en)) == 2'h0)
    else $error("disabled compare pin not low");
  AST_IRQ_MASK:
    assert property ($past(ien) == 3'h0 |-> !o_timer_irq)
    else $error("interrupt with all enables clear");
endmodule

bind frt_timer frt_timer_chk i_chk (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
  .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat),
  .o_wb_ack(o_wb_ack), .i_capture_pin(i_capture_pin),
  .i_pin_is_input(i_pin_is_input), .o_compare_pin(o_compare_pin),
  .o_compare_pin_oe(o_compare_pin_oe), .o_timer_irq(o_timer_irq)
);
`default_nettype wire

/* bench/frt_timer_tb_top.sv */
// Self-checking bench for the free-running timer
`timescale 1ns/100ps
`default_nettype none
module frt_timer_tb_top
  import frt_pkg::*;
;
  logic        i_clk, i_rst_b, i_wb_cyc, i_wb_stb, i_wb_we;
  logic [7:0]  i_wb_adr;
  logic [3:0]  i_wb_sel;
  logic [31:0] i_wb_dat, o_wb_dat;
  logic        o_wb_ack, o_timer_irq;
  logic [1:0]  i_capture_pin, i_pin_is_input, o_compare_pin;
  logic [1:0]  o_compare_pin_oe, ph;
  logic [15:0] mdl_cnt, snap, t;  // Count model, count at take
  logic [7:0]  rb;                // Last read byte
  logic [5:0]  hix;               // High index of a counter pair
  int          miscompares, n_checks;

  // Clock
  always #25 i_clk = ~i_clk;

  // Count model for expectations
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ph <= 2'h0;
      mdl_cnt <= 16'h0000;
    end else begin
      ph <= ph + 2'h1;
      if (ph == 2'h3) mdl_cnt <= mdl_cnt + 16'h0001;
    end
  end

  frt_timer i_frt_timer (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
    .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack), .i_capture_pin(i_capture_pin),
    .i_pin_is_input(i_pin_is_input), .o_compare_pin(o_compare_pin),
    .o_compare_pin_oe(o_compare_pin_oe), .o_timer_irq(o_timer_irq)
  );

  // One classic Wishbone cycle
  task automatic bus(input logic we, input logic [5:0] idx,
                     input logic [7:0] wd, input logic [3:0] sel);
    int n = 0;
    @(posedge i_clk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= we;
    i_wb_adr <= {idx, 2'h0};
    i_wb_sel <= sel;
    i_wb_dat <= {24'h000000, wd};
    @(posedge i_clk);
    snap = mdl_cnt;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 20);
    if (n == 20) begin
      miscompares++;
      $display("[FAIL] %0t no ack", $time);
    end
    rb = o_wb_dat[7:0];
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] idx);
    bus(1'b0, idx, 8'h00, 4'hf);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'h1);
  endtask

  // High byte first, then low byte
  task automatic wr16(input logic [5:0] idx, input logic [15:0] v);
    wr(idx, v[15:8]);
    wr(idx + 6'h01, v[7:0]);
  endtask

  task automatic chk(input logic [7:0] got, exp, msk, input string what);
    n_checks++;
    if ((got & msk) !== (exp & msk)) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge i_clk);
    miscompares++;
    $display("[FAIL] %0t watchdog expired", $time);
    final_report;
  end

  // Test sequence
  initial begin
    {i_clk, i_rst_b, i_wb_cyc, i_wb_stb, i_wb_we} = 5'h00;
    {i_wb_adr, i_wb_sel, i_wb_dat} = 44'h0;
    i_capture_pin = 2'h2;
    i_pin_is_input = 2'h0;
    miscompares = 0;
    n_checks = 0;
    repeat (12) @(posedge i_clk);
    i_rst_b <= 1'b1;
    rd(IDX_CTL1); chk(rb, 8'h00, 8'hf8, "ctl1 reset");
    rd(IDX_CTL2); chk(rb, 8'h00, 8'hfe, "ctl2 reset");
    wr(IDX_STATUS, 8'hff);
    rd(IDX_STATUS); chk(rb, 8'h04, 8'h1d, "status");
    rd(6'h10); chk(rb, 8'h00, 8'hff, "unmapped");
    $display("test reset done");
    wr16(IDX_CMP1_HI, 16'h1234);
    wr(IDX_CMP1_HI, 8'h56);
    bus(1'b1, IDX_CMP1_LO, 8'hee, 4'h0);
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    repeat (12) @(posedge i_clk);
    i_rst_b <= 1'b1;
    rd(IDX_CMP1_HI); chk(rb, 8'h56, 8'hff, "cmp hi");
    rd(IDX_CMP1_LO); chk(rb, 8'h34, 8'hff, "cmp lo");
    $display("test storage done");
    for (int p = 0; p < 2; p++) begin
      hix = (p == 0) ? IDX_CNT_HI : IDX_ALT_HI;
      rd(hix); t = snap; chk(rb, t[15:8], 8'hff, "cnt hi");
      repeat (40) @(posedge i_clk);
      rd(hix); chk(rb, snap[15:8], 8'hff, "cnt hi again");
      rd(hix + 6'h01); chk(rb, t[7:0], 8'hff, "latched lo");
      rd(hix + 6'h01); chk(rb, snap[7:0], 8'hff, "live lo");
    end
    $display("test counter done");
    wr(IDX_CTL2, 8'h29);
    wr16(IDX_CMP2_HI, mdl_cnt + 16'h000c);
    repeat (80) @(posedge i_clk);
    chk({6'h0, o_compare_pin}, 8'h02, 8'h02, "pin2 set");
    chk({7'h0, o_timer_irq}, 8'h01, 8'h01, "irq2");
    rd(IDX_STATUS); chk(rb, 8'h02, 8'h02, "flag2");
    t = mdl_cnt + 16'h07d0;
    wr(IDX_CMP2_HI, t[15:8]);
    rd(IDX_STATUS);
    wr(IDX_CMP2_LO, t[7:0]);
    rd(IDX_STATUS); chk(rb, 8'h00, 8'h02, "flag2 clear");
    wr(IDX_CTL2, 8'h28);
    t = mdl_cnt + 16'h0028;
    wr(IDX_CMP2_LO, t[7:0]);
    wr(IDX_CMP2_HI, t[15:8]);
    repeat (240) @(posedge i_clk);
    chk({6'h0, o_compare_pin}, 8'h02, 8'h02, "inhibited pin");
    chk({7'h0, o_timer_irq}, 8'h00, 8'h01, "inhibited irq");
    wr(IDX_CMP2_LO, t[7:0]);
    wr16(IDX_CMP2_HI, mdl_cnt + 16'h000c);
    repeat (80) @(posedge i_clk);
    chk({6'h0, o_compare_pin}, 8'h00, 8'h02, "pin2 low");
    chk({7'h0, o_timer_irq}, 8'h01, 8'h01, "irq2 again");
    wr(IDX_CTL2, 8'h29);
    wr16(IDX_CMP2_HI, mdl_cnt + 16'h000c);
    repeat (80) @(posedge i_clk);
    chk({6'h0, o_compare_pin}, 8'h02, 8'h02, "pin2 flag set");
    rd(IDX_STATUS); chk(rb, 8'h02, 8'h02, "flag2 kept");
    wr(IDX_CTL2, 8'h09);
    repeat (3) @(posedge i_clk);
    chk({7'h0, o_timer_irq}, 8'h00, 8'h01, "irq masked");
    wr(IDX_CTL2, 8'h21);
    repeat (3) @(posedge i_clk);
    chk({6'h0, o_compare_pin}, 8'h00, 8'h02, "pin2 off");
    $display("test channel two done");
    i_pin_is_input <= 2'h1;
    wr(IDX_CTL1, 8'h09);
    wr16(IDX_CMP1_HI, mdl_cnt + 16'h000c);
    repeat (80) @(posedge i_clk);
    chk({6'h0, o_compare_pin_oe}, 8'h02, 8'h03, "oe input");
    chk({6'h0, o_compare_pin}, 8'h00, 8'h01, "pin1 input");
    i_pin_is_input <= 2'h0;
    wr16(IDX_CMP1_HI, mdl_cnt + 16'h000c);
    repeat (80) @(posedge i_clk);
    chk({6'h0, o_compare_pin_oe}, 8'h03, 8'h03, "oe output");
    chk({6'h0, o_compare_pin}, 8'h01, 8'h01, "pin1 set");
    rd(IDX_STATUS); chk(rb, 8'h20, 8'h20, "flag1");
    $display("test channel one done");
    final_report;
  end
endmodule
`default_nettype wire
